// ===== pkg/scp_pkg.sv
// ***************************************************************
// Serial control port constants
// ***************************************************************
package scp_pkg;
  // Instruction word layout
  localparam int          INSTR_BITS = 16;
  localparam int          DIR_POS    = 15;
  localparam int          CNT_HI     = 14;
  localparam int          CNT_LO     = 13;
  localparam int          ADDR_W     = 13;
  // Register map of the port buffer
  localparam logic [12:0] REG_LAST   = 13'h005a;
  localparam int          REG_NUM    = 91;
  localparam logic [6:0]  CFG_IDX    = 7'h00;
  localparam int          BIDIR_BIT  = 7;
  localparam int          LSB_BIT    = 6;
  localparam logic [6:0]  UPD_IDX    = 7'h5a;
  localparam int          UPD_BIT    = 0;
  localparam logic [7:0]  REG_RESET  = 8'h00;
  // Registers whose effect waits for a sync event
  localparam logic [6:0]  GATE_LO    = 7'h30;
  localparam logic [6:0]  GATE_HI    = 7'h3f;
  // Wishbone word indexes (byte address is four times the index)
  localparam logic [7:0]  EFF_BASE   = 8'h80;
  localparam logic [7:0]  SYNC_IDX   = 8'he0;
  localparam int          SYNC_BIT   = 0;
  localparam logic [7:0]  STAT_IDX   = 8'he1;
endpackage

// ===== core/scp_sync.sv
`timescale 1ns/1ps
// ***************************************************************
// Two-flop synchroniser for the serial port pins
// ***************************************************************
module scp_sync #(
  parameter int W = 3
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;

  // One pair of flops per pin; the first flop feeds only the second
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : gSync
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          meta[g] <= 1'b1;
          dout[g] <= 1'b1;
        end else begin
          meta[g] <= din[g];
          dout[g] <= meta[g];
        end
      end
    end
  endgenerate
endmodule

// ===== core/scp_port.sv
`timescale 1ns/1ps
module scp_port (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        sclk,
  input  wire logic        selectLowPinN,
  input  wire logic        sdioIn,
  output logic             sdioOut,
  output logic             sdioOe,
  output logic             readbackOutPin,
  output logic             readbackOutOe,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA, ST_DONE} scp_state_t;

  // ***************************************************************
  // Pin synchronisation and edge detection
  // ***************************************************************
  logic [2:0] pinS;
  logic       sclkS, csbS, sdiS, sclkD, rise, fall;

  scp_sync #(.W(3)) uSync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     ({sclk, selectLowPinN, sdioIn}),
    .dout    (pinS)
  );
  assign sclkS = pinS[2];
  assign csbS  = pinS[1];
  assign sdiS  = pinS[0];

  // Link clock is far slower than ref_clk, so edges are found by sampling
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclkD <= 1'b1;  // Matches the synchroniser's reset level: no false rise
    end else begin
      sclkD <= sclkS;
    end
  end
  assign rise = sclkS & ~sclkD;
  assign fall = ~sclkS & sclkD;

  // ***************************************************************
  // Register storage
  // ***************************************************************
  logic [7:0] shadowReg [0:scp_pkg::REG_NUM-1];
  logic [7:0] activeReg [0:scp_pkg::REG_NUM-1];
  logic [7:0] effReg    [0:scp_pkg::REG_NUM-1];
  logic       wrStb, updateReq, syncEvt;
  logic [6:0] wrIdx;
  logic [7:0] wrData;

  // Out-of-map addresses read as zero rather than aliasing
  function automatic logic [7:0] shadowAt(input logic [12:0] a);
    if (a <= scp_pkg::REG_LAST) begin
      return shadowReg[a[6:0]];
    end
    return 8'h00;
  endfunction

  // Shadow buffer: serial writes land here only; update bit self-clears
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < scp_pkg::REG_NUM; i++) begin
        shadowReg[i] <= scp_pkg::REG_RESET;
      end
    end else begin
      if (wrStb) begin
        shadowReg[wrIdx] <= wrData;
      end
      if (updateReq) begin
        shadowReg[scp_pkg::UPD_IDX][scp_pkg::UPD_BIT] <= 1'b0;
      end
    end
  end

  // Update command registered on the same edge that the byte reaches the shadow
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      updateReq <= 1'b0;
    end else begin
      updateReq <= wrStb && wrIdx == scp_pkg::UPD_IDX
                   && wrData[scp_pkg::UPD_BIT];
    end
  end

  // Active registers take the whole buffer at once
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < scp_pkg::REG_NUM; i++) begin
        activeReg[i] <= scp_pkg::REG_RESET;
      end
    end else if (updateReq) begin
      for (int i = 0; i < scp_pkg::REG_NUM; i++) begin
        activeReg[i] <= shadowReg[i];
      end
    end
  end

  // Effective values: gated phase/alignment group waits for a sync
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < scp_pkg::REG_NUM; i++) begin
        effReg[i] <= scp_pkg::REG_RESET;
      end
    end else begin
      for (int i = 0; i < scp_pkg::REG_NUM; i++) begin
        if (7'(i) < scp_pkg::GATE_LO || 7'(i) > scp_pkg::GATE_HI) begin
          effReg[i] <= activeReg[i];
        end else if (syncEvt) begin
          effReg[i] <= activeReg[i];
        end
      end
    end
  end

  // ***************************************************************
  // Serial transfer state machine
  // ***************************************************************
  scp_state_t  state;
  logic [3:0]  cnt;
  logic [15:0] instrSh;
  logic [7:0]  dataSh, rdByte, pendData;
  logic [12:0] addr;
  logic [2:0]  bytesLeft;
  logic        isRead, lsbLat;
  logic [15:0] next_instr;
  logic [7:0]  next_data;
  logic [12:0] next_addr;

  // Bit order fixed per frame from the config byte at frame start
  assign next_instr = lsbLat ? {sdiS, instrSh[15:1]}
                             : {instrSh[14:0], sdiS};
  assign next_data  = lsbLat ? {sdiS, dataSh[7:1]} : {dataSh[6:0], sdiS};
  // No skipping of holes in the map; controller must avoid them
  assign next_addr  = lsbLat ? 13'(addr + 13'h0001)
                             : 13'(addr - 13'h0001);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state     <= ST_IDLE;
      cnt       <= 4'h0;
      instrSh   <= 16'h0000;
      dataSh    <= 8'h00;
      rdByte    <= 8'h00;
      pendData  <= 8'h00;
      addr      <= 13'h0000;
      bytesLeft <= 3'h0;
      isRead    <= 1'b0;
      lsbLat    <= 1'b0;
      wrStb     <= 1'b0;
      wrIdx     <= 7'h00;
      wrData    <= 8'h00;
    end else begin
      wrStb <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (!csbS) begin
            state  <= ST_INSTR;
            cnt    <= 4'h0;
            lsbLat <= shadowReg[scp_pkg::CFG_IDX][scp_pkg::LSB_BIT];
          end
        end
        ST_INSTR, ST_DATA: begin
          if (csbS) begin
            // Boundary: just wait; inside a byte: drop everything
            // On a boundary the state is kept and shifting resumes
            if (cnt[2:0] != 3'h0) begin
              state <= ST_IDLE;
            end
          end else if (rise) begin
            cnt <= 4'(cnt + 4'h1);
            if (state == ST_INSTR) begin
              instrSh <= next_instr;
              if (cnt == 4'(scp_pkg::INSTR_BITS - 1)) begin
                state     <= ST_DATA;
                cnt       <= 4'h0;
                isRead    <= next_instr[scp_pkg::DIR_POS];
                bytesLeft <= 3'({1'b0, next_instr[scp_pkg::CNT_HI:
                                 scp_pkg::CNT_LO]} + 3'h1);
                addr      <= next_instr[scp_pkg::ADDR_W-1:0];
                rdByte    <= shadowAt(next_instr[scp_pkg::ADDR_W-1:0]);
              end
            end else begin
              dataSh <= next_data;
              if (cnt[2:0] == 3'h7) begin
                cnt       <= 4'h0;
                bytesLeft <= 3'(bytesLeft - 3'h1);
                if (!isRead && bytesLeft != 3'h1 && addr <= scp_pkg::REG_LAST)
                begin
                  wrStb  <= 1'b1;
                  wrIdx  <= addr[6:0];
                  wrData <= next_data;
                end
                if (bytesLeft == 3'h1) begin
                  pendData <= next_data;
                  state    <= ST_DONE;
                end else begin
                  addr   <= next_addr;
                  rdByte <= shadowAt(next_addr);
                end
              end
            end
          end
        end
        ST_DONE: begin
          // Last write byte commits only on a clean select release
          if (csbS) begin
            state <= ST_IDLE;
            if (!isRead && addr <= scp_pkg::REG_LAST) begin
              wrStb  <= 1'b1;
              wrIdx  <= addr[6:0];
              wrData <= pendData;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // Readback drivers
  // ***************************************************************
  logic bidir, rdActive, outBit;
  assign bidir    = shadowReg[scp_pkg::CFG_IDX][scp_pkg::BIDIR_BIT];
  assign rdActive = state == ST_DATA && isRead && !csbS;

  // Bits launched on falling edges so they are stable for the sampler
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      outBit <= 1'b0;
    end else if (fall && rdActive) begin
      outBit <= lsbLat ? rdByte[cnt[2:0]]
                       : rdByte[3'(3'h7 - cnt[2:0])];
    end
  end

  // Pin selection and high impedance while select is high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      readbackOutPin <= 1'b0;
      readbackOutOe  <= 1'b0;
      sdioOut        <= 1'b0;
      sdioOe         <= 1'b0;
    end else begin
      readbackOutPin <= outBit;
      sdioOut        <= outBit;
      readbackOutOe  <= rdActive && !bidir;
      sdioOe         <= rdActive && bidir;
    end
  end

  // ***************************************************************
  // Wishbone slave: active, effective, sync and status words
  // ***************************************************************
  logic [7:0] wbIdx, effIdx;
  assign wbIdx  = wb_adr_i[9:2];
  assign effIdx = 8'(wbIdx - scp_pkg::EFF_BASE);

  // Ack one cycle after the strobe; unmapped words read zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      syncEvt  <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      syncEvt  <= wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
                  && wb_sel_i[0] && wbIdx == scp_pkg::SYNC_IDX
                  && wb_dat_i[scp_pkg::SYNC_BIT];
      wb_dat_o <= 32'h0000_0000;
      if ({5'h00, wbIdx} <= scp_pkg::REG_LAST) begin
        wb_dat_o[7:0] <= activeReg[wbIdx[6:0]];
      end else if (wbIdx >= scp_pkg::EFF_BASE
                   && {5'h00, effIdx} <= scp_pkg::REG_LAST) begin
        wb_dat_o[7:0] <= effReg[effIdx[6:0]];
      end else if (wbIdx == scp_pkg::STAT_IDX) begin
        wb_dat_o[7:0] <= {3'h0, bidir, lsbLat, isRead, 2'(state)};
      end
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  sequence sEndInstr;
    state == ST_INSTR && !csbS && rise && cnt == 4'hf;
  endsequence
  sequence sEndByte;
    state == ST_DATA && !csbS && rise && cnt[2:0] == 3'h7;
  endsequence

  a_pins_idle_off: assert property (@(posedge ref_clk) disable iff (rst)
    csbS |=> !readbackOutOe && !sdioOe)
    else $error("readback driven while select high");
  a_midbyte_abort: assert property (@(posedge ref_clk) disable iff (rst)
    (state != ST_IDLE && state != ST_DONE && csbS && cnt[2:0] != 3'h0)
    |=> state == ST_IDLE)
    else $error("partial byte did not abort");
  a_boundary_stall: assert property (@(posedge ref_clk) disable iff (rst)
    (state == ST_DATA && csbS && cnt[2:0] == 3'h0) |=> state == ST_DATA)
    else $error("stall lost the transfer");
  a_instr_to_data: assert property (@(posedge ref_clk) disable iff (rst)
    sEndInstr |=> state == ST_DATA && cnt == 4'h0
                  && bytesLeft == 3'({1'b0, instrSh[scp_pkg::CNT_HI:
                                      scp_pkg::CNT_LO]} + 3'h1))
    else $error("instruction not taken after 16 edges");
  a_count_code: assert property (@(posedge ref_clk) disable iff (rst)
    sEndInstr |=> bytesLeft >= 3'h1 && bytesLeft <= 3'h4)
    else $error("byte count outside one to four");
  a_addr_step: assert property (@(posedge ref_clk) disable iff (rst)
    (sEndByte ##0 bytesLeft > 3'h1) |=>
      addr == ($past(lsbLat) ? 13'($past(addr) + 13'h0001)
                             : 13'($past(addr) - 13'h0001)))
    else $error("address step wrong");
  a_update_copy: assert property (@(posedge ref_clk) disable iff (rst)
    updateReq |=> activeReg[scp_pkg::CFG_IDX] == $past(shadowReg[0]))
    else $error("update did not copy buffer");
  a_update_clear: assert property (@(posedge ref_clk) disable iff (rst)
    updateReq |=> !shadowReg[scp_pkg::UPD_IDX][scp_pkg::UPD_BIT])
    else $error("update bit not self-cleared");
  a_sync_gate: assert property (@(posedge ref_clk) disable iff (rst)
    !syncEvt |=> $stable(effReg[scp_pkg::GATE_LO + 7'h05]))
    else $error("gated setting changed without sync");
  a_final_commit: assert property (@(posedge ref_clk) disable iff (rst)
    (state == ST_DONE && csbS && !isRead && addr <= scp_pkg::REG_LAST)
    |=> wrStb ##1 shadowReg[$past(addr[6:0], 2)] == $past(pendData, 2))
    else $error("final byte not loaded on release");
endmodule

// ===== test/scp_master_model.sv
`timescale 1ns/1ps
// ***************************************************************
// Serial bus controller model
// ***************************************************************
module scp_master_model (
  input  wire logic ref_clk,
  input  wire logic rdBit,
  output logic      sclk,
  output logic      selectLowPinN,
  output logic      mDat,
  output logic      mOe
);
  // Link rests with clock low and select high
  initial begin
    sclk          = 1'b0;
    selectLowPinN = 1'b1;
    mDat          = 1'b0;
    mOe           = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One 320 ns shift clock; a released line toggles so no stale bit lingers
  task automatic bit_io(input logic d, input logic drive, output logic q);
    mOe  <= drive;
    mDat <= drive ? d : ~mDat;
    tick(4);
    sclk <= 1'b1;  // Rising edge carries write bits
    tick(2);
    q = rdBit;  // Read bit has settled since the falling edge
    tick(2);
    sclk <= 1'b0;
  endtask

  // Select rises only after a whole byte, else the last byte is lost
  task automatic release_sel();
    tick(4);
    selectLowPinN <= 1'b1;
    mOe           <= 1'b0;
    tick(8);
  endtask

  // Instruction then n whole bytes, optionally pausing before each byte
  task automatic frame(input logic lsb, input logic [15:0] instr,
                       input int n, input logic [31:0] wd,
                       input logic stall, output logic [31:0] rq);
    logic q;
    int   k;
    rq = 32'h0;
    selectLowPinN <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      bit_io(instr[lsb ? i : 15 - i], 1'b1, q);
    end
    for (int b = 0; b < n; b++) begin
      if (stall) begin
        selectLowPinN <= 1'b1;  // Pause on a byte boundary
        tick(16);
        selectLowPinN <= 1'b0;
      end
      for (int i = 0; i < 8; i++) begin
        k = 8 * b + (lsb ? i : 7 - i);
        bit_io(wd[k], !instr[15], q);  // Line released for reads
        rq[k] = q;
      end
    end
    release_sel();
  endtask

  // Deliberately cut a frame after nb bits, MSB first
  task automatic partial(input logic [15:0] instr, input int nb);
    logic q;
    selectLowPinN <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      bit_io(instr[(31 - i) % 16], 1'b1, q);
    end
    release_sel();
  endtask
endmodule

// ===== test/serial_config_port_transfer_tb_top.sv
`timescale 1ns/1ps
module serial_config_port_transfer_tb_top;
  logic        ref_clk;
  logic        rst;
  logic        sclk;
  logic        selectLowPinN;
  logic        sdioIn;
  logic        sdioOut;
  logic        sdioOe;
  logic        readbackOutPin;
  logic        readbackOutOe;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        mDat;
  logic        mOe;
  logic        rdBit;
  logic [31:0] r;
  int          fails = 0;
  int          checks = 0;
  int          sepCnt = 0;
  int          shCnt = 0;

  // Shared pin resolves to whoever drives it; an idle pin reads inverted
  assign sdioIn = sdioOe ? sdioOut : mDat;
  assign rdBit  = sdioOe ? sdioOut : (readbackOutOe ? readbackOutPin : ~mDat);

  scp_port dut (.ref_clk(ref_clk), .rst(rst), .sclk(sclk),
    .selectLowPinN(selectLowPinN), .sdioIn(sdioIn), .sdioOut(sdioOut),
    .sdioOe(sdioOe), .readbackOutPin(readbackOutPin),
    .readbackOutOe(readbackOutOe), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));

  scp_master_model master (.ref_clk(ref_clk), .rdBit(rdBit), .sclk(sclk),
    .selectLowPinN(selectLowPinN), .mDat(mDat), .mOe(mOe));

  // Clock at 25 MHz
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Count cycles in which each readback pin is driven
  always @(posedge ref_clk) begin
    if (readbackOutOe === 1'b1) sepCnt <= sepCnt + 1;
    if (sdioOe === 1'b1) shCnt <= shCnt + 1;
  end

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Classic single Wishbone cycle; waits for ack under a bound
  task automatic wb(input logic [7:0] idx, input logic we,
                    input logic [7:0] wd, output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, wd};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      $display("ERROR wbAck expected 1 seen %b", wb_ack_o);
      give_verdict();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic spi(input logic lsb, input logic rd, input logic [1:0] cnt,
                     input logic [6:0] a, input logic [31:0] wd,
                     input logic stall, output logic [31:0] rq);
    // Upper address bits always sent as zero
    master.frame(lsb, {rd, cnt, 6'h00, a}, int'(cnt) + 1, wd, stall, rq);
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic test_reset();
    check("sepOe", 32'h0, readbackOutOe);
    check("sharedOe", 32'h0, sdioOe);
    wb(8'he1, 1'b0, 8'h00, r);
    check("status", 32'h0, r);
  endtask

  task automatic test_write_update();
    int s;
    s = sepCnt;
    spi(0, 0, 2'b00, 7'h10, 32'h5c, 0, r);
    wb(8'h10, 1'b0, 8'h00, r);
    check("activeBefore", 32'h0, r);
    spi(0, 1, 2'b00, 7'h10, 32'h0, 0, r);
    check("read10", 32'h5c, r);
    check("sepUsed", 32'h1, sepCnt > s);
    check("sepOff", 32'h0, readbackOutOe);
    spi(0, 0, 2'b00, 7'h5a, 32'h01, 0, r);
    wb(8'h10, 1'b0, 8'h00, r);
    check("activeAfter", 32'h5c, r);
    spi(0, 1, 2'b00, 7'h5a, 32'h0, 0, r);
    check("updSelfClear", 32'h0, r);
  endtask

  task automatic test_multi();
    spi(0, 0, 2'b10, 7'h22, 32'h00c3b2a1, 1, r);
    spi(0, 1, 2'b11, 7'h22, 32'h0, 0, r);
    check("read4", 32'h00c3b2a1, r);
    spi(0, 0, 2'b00, 7'h5a, 32'h01, 0, r);
    wb(8'h21, 1'b0, 8'h00, r);
    check("active21", 32'hb2, r);
  endtask

  task automatic test_abort();
    master.partial(16'h0010, 20);
    wb(8'he1, 1'b0, 8'h00, r);
    check("stateIdle", 32'h0, r & 32'h3);
    spi(0, 1, 2'b00, 7'h10, 32'h0, 0, r);
    check("keep10", 32'h5c, r);
  endtask

  task automatic test_gated();
    spi(0, 0, 2'b01, 7'h35, 32'h6677, 0, r);
    spi(0, 0, 2'b00, 7'h5a, 32'h01, 0, r);
    wb(8'hb5, 1'b0, 8'h00, r);
    check("effBefore", 32'h0, r);
    wb(8'h34, 1'b0, 8'h00, r);
    check("active34", 32'h66, r);
    wb(8'he0, 1'b1, 8'h01, r);
    wb(8'hb5, 1'b0, 8'h00, r);
    check("effAfter", 32'h77, r);
    wb(8'hf0, 1'b0, 8'h00, r);
    check("unmapped", 32'h0, r);
  endtask

  task automatic test_lsb_bidir();
    int s;
    int p;
    spi(0, 0, 2'b00, 7'h00, 32'h40, 0, r);
    spi(1, 0, 2'b01, 7'h40, 32'hd2e1, 0, r);
    spi(1, 1, 2'b01, 7'h40, 32'h0, 0, r);
    check("readLsb", 32'hd2e1, r);
    spi(1, 0, 2'b00, 7'h00, 32'hc0, 0, r);
    s = shCnt;
    p = sepCnt;
    spi(1, 1, 2'b00, 7'h40, 32'h0, 0, r);
    check("readShared", 32'he1, r);
    check("sharedUsed", 32'h1, shCnt > s);
    check("sepIdle", p, sepCnt);
    check("sharedOff", 32'h0, sdioOe);
  endtask

  // Watchdog cuts a hang short
  initial begin
    repeat (30000) @(posedge ref_clk);
    fails++;
    $display("ERROR watchdog expected done seen timeout");
    give_verdict();
  end

  // Main sequence
  initial begin
    rst      = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 10'h000;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    test_reset();
    test_write_update();
    test_multi();
    test_abort();
    test_gated();
    test_lsb_bidir();
    give_verdict();
  end
endmodule
